// ### src/atr_top.sv
// Notes on behaviour
// RULE1: each target picks any source freely
// RULE2: timers give positive, negative pulse or square
// RULE3: timer periods are multiples of base period; code ticks once per 100000 ps clock, not per 66700 ps
// RULE4: two external inputs are sources
// RULE5: dsp strobe register write makes one pulse
// RULE6: host strobe register write makes one pulse
// RULE7: constant low and high are sources
// RULE8: converter clock rising edge starts conversion
// RULE9: clock edge counts only while gate high
// RULE10: external clock output follows its source
// RULE11: rising edge on host target raises irq
// RULE12: rising edge on dsp target raises irq
// RULE13: all eight channels sampled together, 16 bit
// RULE14: state machine copies all results into fifo; code drops words while fifo is full and flags overflow
// RULE15: fifo level at threshold raises dsp irq
// RULE16: per channel gain one, two, four, eight
// RULE17: edges detected on synchronised signals, pulses
// RULE18: all routes reset to constant low
`default_nettype none
module atr_top
(
   input  wire logic                mclk_i,
   input  wire logic                resetn_i,
   input  wire logic [4:0]          avs_address,
   input  wire logic                avs_read,
   input  wire logic                avs_write,
   input  wire logic [31:0]         avs_writedata,
   output logic [31:0]              avs_readdata,
   output logic                     avs_waitrequest,
   input  wire logic [1:0]          ext_trig_i,
   output logic                     ext_clk_o,
   output logic                     adc_convst_o,
   input  wire logic                adc_done_i,
   input  wire logic [127:0]        adc_data_i,
   output logic [15:0]              pga_gain_o,
   output logic                     host_irq_o,
   output logic                     dsp_irq_o
);
   // ==================================================================
   // registers
   logic [3:0]  route_reg [atr_pkg::NUM_TGT];
   logic [2:0]  tcfg_reg [2];
   logic [15:0] tper_reg [2];
   logic [15:0] gain_reg;
   logic [6:0]  thresh_reg;
   logic [3:0]  irq_stat_reg;
   logic [3:0]  irq_en_reg;
   logic        dsp_stb_reg;
   logic        host_stb_reg;
   logic        ack_reg;
   logic [1:0]  ext_s1_reg;
   logic [1:0]  ext_s2_reg;
   logic        done_s1_reg;
   logic        done_s2_reg;
   logic        done_d_reg;
   logic [4:0]  tgt_d_reg;
   logic [4:0]  tgt_reg;
   logic [15:0] fifo_mem [atr_pkg::FIFO_DEPTH];
   logic [5:0]  wr_ptr_reg;
   logic [5:0]  rd_ptr_reg;
   logic [6:0]  level_reg;
   logic [2:0]  ch_reg;
   logic [127:0] samp_reg;
   atr_pkg::atr_cap_t state_reg;
   // ==================================================================
   // bus decode
   wire       acc     = (avs_read || avs_write) && !ack_reg;
   wire       wr      = avs_write && !ack_reg;
   wire       rd      = avs_read && !ack_reg;
   wire       wr_route = wr && (avs_address < 5'(atr_pkg::NUM_TGT));
   wire       wr_t0   = wr && (avs_address == atr_pkg::A_TMRCFG0);
   wire       wr_t1   = wr && (avs_address == atr_pkg::A_TMRCFG1);
   wire       wr_dstb = wr && (avs_address == atr_pkg::A_DSPSTB);
   wire       wr_hstb = wr && (avs_address == atr_pkg::A_HOSTSTB);
   wire       wr_gain = wr && (avs_address == atr_pkg::A_GAIN);
   wire       wr_thr  = wr && (avs_address == atr_pkg::A_THRESH);
   wire       wr_en   = wr && (avs_address == atr_pkg::A_IRQEN);
   wire       wr_clr  = wr && (avs_address == atr_pkg::A_IRQCLR);
   wire       rd_fifo = rd && (avs_address == atr_pkg::A_FIFO);
   wire       fifo_empty = (level_reg == 7'h00);
   wire       fifo_full  = (level_reg == 7'(atr_pkg::FIFO_DEPTH));
   wire       pop     = rd_fifo && !fifo_empty;
   // ==================================================================
   // sources
   logic [1:0] tmr_out;
   logic [4:0] tgt_next;
   wire [7:0] src = {host_stb_reg, dsp_stb_reg, ext_s2_reg, tmr_out, 1'b1, 1'b0}; // RULE4 RULE7
   genvar gt;
   generate
      for (gt = 0; gt < 2; gt++)
      begin : g_tmr
         atr_timer u_tmr // RULE3
         (
            .mclk_i   (mclk_i),
            .resetn_i (resetn_i),
            .en_i     (tcfg_reg[gt][2]),
            .mode_i   (tcfg_reg[gt][1:0]),
            .period_i (tper_reg[gt]),
            .out_o    (tmr_out[gt])
         );
      end
      for (gt = 0; gt < atr_pkg::NUM_TGT; gt++)
      begin : g_tgt
         assign tgt_next[gt] = src[route_reg[gt][2:0]]; // RULE1
      end
   endgenerate
   // ==================================================================
   // events
   wire adclk_rise = tgt_reg[atr_pkg::TGT_ADCLK] && !tgt_d_reg[atr_pkg::TGT_ADCLK]; // RULE17
   wire conv_go  = adclk_rise && tgt_reg[atr_pkg::TGT_ADGATE]; // RULE8 RULE9
   wire host_ev  = tgt_reg[atr_pkg::TGT_HOSTIRQ] && !tgt_d_reg[atr_pkg::TGT_HOSTIRQ]; // RULE11
   wire dsp_ev   = tgt_reg[atr_pkg::TGT_DSPIRQ] && !tgt_d_reg[atr_pkg::TGT_DSPIRQ]; // RULE12
   wire done_ev  = done_s2_reg && !done_d_reg;
   wire push     = (state_reg == atr_pkg::CAP_COPY) && !fifo_full;
   wire ovf_ev   = (state_reg == atr_pkg::CAP_COPY) && fifo_full;
   wire thr_ev   = (level_reg >= thresh_reg) && (thresh_reg != 7'h00); // RULE15
   wire [3:0] ev = {ovf_ev, thr_ev, dsp_ev, host_ev};
   wire [3:0] stat_next = ev | (irq_stat_reg & ~(wr_clr ? avs_writedata[3:0] : 4'h0));
   wire [15:0] samp_word = samp_reg[ch_reg*16 +: 16];
   logic [31:0] rdata;
   assign rdata =
      (avs_address < 5'(atr_pkg::NUM_TGT)) ? {28'h0000000, route_reg[avs_address[2:0]]} :
      (avs_address == atr_pkg::A_TMRCFG0) ? {13'h0000, tcfg_reg[0], tper_reg[0]} :
      (avs_address == atr_pkg::A_TMRCFG1) ? {13'h0000, tcfg_reg[1], tper_reg[1]} :
      (avs_address == atr_pkg::A_GAIN)    ? {16'h0000, gain_reg} :
      (avs_address == atr_pkg::A_THRESH)  ? {25'h0000000, thresh_reg} :
      (avs_address == atr_pkg::A_FIFO)    ? {16'h0000, fifo_mem[rd_ptr_reg]} :
      (avs_address == atr_pkg::A_LEVEL)   ? {25'h0000000, level_reg} :
      (avs_address == atr_pkg::A_IRQSTAT) ? {28'h0000000, irq_stat_reg} :
      (avs_address == atr_pkg::A_IRQEN)   ? {28'h0000000, irq_en_reg} :
      atr_pkg::RD_UNMAPPED;
   // ==================================================================
   // bus slave: one wait state, answer at second edge
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         ack_reg         <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end
      else
      begin
         ack_reg <= acc;
         avs_waitrequest <= !acc;
         if (rd)
            avs_readdata <= fifo_empty && rd_fifo ? 32'h0000_0000 : rdata;
      end
   end
   // ==================================================================
   // configuration
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         for (int i = 0; i < atr_pkg::NUM_TGT; i++)
            route_reg[i] <= atr_pkg::SRC_LOW; // RULE18
         for (int i = 0; i < 2; i++)
         begin
            tcfg_reg[i] <= 3'h0;
            tper_reg[i] <= atr_pkg::TMR_PER_RST;
         end
         gain_reg     <= {8{atr_pkg::GAIN_RST}};
         thresh_reg   <= atr_pkg::THRESH_RST;
         irq_en_reg   <= 4'h0;
         dsp_stb_reg  <= 1'b0;
         host_stb_reg <= 1'b0;
      end
      else
      begin
         if (wr_route)
            route_reg[avs_address[2:0]] <= avs_writedata[3:0];
         if (wr_t0)
            {tcfg_reg[0], tper_reg[0]} <= avs_writedata[18:0];
         if (wr_t1)
            {tcfg_reg[1], tper_reg[1]} <= avs_writedata[18:0];
         if (wr_gain)
            gain_reg <= avs_writedata[15:0]; // RULE16
         if (wr_thr)
            thresh_reg <= avs_writedata[6:0];
         if (wr_en)
            irq_en_reg <= avs_writedata[3:0];
         dsp_stb_reg  <= wr_dstb; // RULE5
         host_stb_reg <= wr_hstb; // RULE6
      end
   end
   // ==================================================================
   // synchronisers and event state
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         ext_s1_reg   <= 2'h0;
         ext_s2_reg   <= 2'h0;
         done_s1_reg  <= 1'b0;
         done_s2_reg  <= 1'b0;
         done_d_reg   <= 1'b0;
         tgt_reg      <= 5'h00;
         tgt_d_reg    <= 5'h00;
         irq_stat_reg <= 4'h0;
         host_irq_o   <= 1'b0;
         dsp_irq_o    <= 1'b0;
         ext_clk_o    <= 1'b0;
         pga_gain_o   <= {8{atr_pkg::GAIN_RST}};
      end
      else
      begin
         ext_s1_reg   <= ext_trig_i;
         ext_s2_reg   <= ext_s1_reg;
         done_s1_reg  <= adc_done_i;
         done_s2_reg  <= done_s1_reg;
         done_d_reg   <= done_s2_reg;
         tgt_reg      <= tgt_next;
         tgt_d_reg    <= tgt_reg;
         irq_stat_reg <= stat_next;
         host_irq_o   <= stat_next[atr_pkg::IRQ_HOST] & irq_en_reg[atr_pkg::IRQ_HOST];
         dsp_irq_o    <= |(stat_next[3:1] & irq_en_reg[3:1]);
         ext_clk_o    <= tgt_reg[atr_pkg::TGT_EXTOUT]; // RULE10
         pga_gain_o   <= gain_reg;
      end
   end
   // ==================================================================
   // capture fsm and fifo
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         state_reg    <= atr_pkg::CAP_IDLE;
         adc_convst_o <= 1'b0;
         ch_reg       <= 3'h0;
         samp_reg     <= 128'h0;
         wr_ptr_reg   <= 6'h00;
         rd_ptr_reg   <= 6'h00;
         level_reg    <= 7'h00;
      end
      else
      begin
         adc_convst_o <= 1'b0;
         case (state_reg)
            atr_pkg::CAP_IDLE:
               if (conv_go)
               begin
                  adc_convst_o <= 1'b1; // RULE13
                  state_reg    <= atr_pkg::CAP_CONV;
               end
            atr_pkg::CAP_CONV:
               if (done_ev)
               begin
                  samp_reg  <= adc_data_i; // RULE13
                  ch_reg    <= 3'h0;
                  state_reg <= atr_pkg::CAP_COPY;
               end
            atr_pkg::CAP_COPY:
            begin
               ch_reg <= ch_reg + 3'h1; // RULE14
               if (ch_reg == 3'h7)
                  state_reg <= atr_pkg::CAP_IDLE;
            end
            default: state_reg <= atr_pkg::CAP_IDLE;
         endcase
         if (push)
         begin
            fifo_mem[wr_ptr_reg] <= samp_word; // RULE14
            wr_ptr_reg <= wr_ptr_reg + 6'h01;
         end
         if (pop)
            rd_ptr_reg <= rd_ptr_reg + 6'h01;
         level_reg <= level_reg + 7'(push) - 7'(pop);
      end
   end
   // ==================================================================
   // assertions
   sequence s_adclk_edge;
      tgt_reg[atr_pkg::TGT_ADCLK] && !tgt_d_reg[atr_pkg::TGT_ADCLK];
   endsequence
   a_conv_start: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RULE8
      s_adclk_edge and tgt_reg[atr_pkg::TGT_ADGATE] && state_reg == atr_pkg::CAP_IDLE
      |=> adc_convst_o)
      else $error("conversion not started");
   a_gate_block: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RULE9
      !tgt_reg[atr_pkg::TGT_ADGATE] && state_reg == atr_pkg::CAP_IDLE |=> !adc_convst_o)
      else $error("conversion without gate");
   a_dsp_strobe: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RULE5
      wr_dstb |=> dsp_stb_reg ##1 !dsp_stb_reg)
      else $error("dsp strobe not single pulse");
   a_host_strobe: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RULE6
      wr_hstb |=> host_stb_reg ##1 !host_stb_reg)
      else $error("host strobe not single pulse");
   a_host_irq: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RULE11
      host_ev && irq_en_reg[atr_pkg::IRQ_HOST] |=> host_irq_o)
      else $error("host irq missing");
   a_dsp_irq: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RULE12
      dsp_ev && irq_en_reg[atr_pkg::IRQ_DSP] |=> dsp_irq_o)
      else $error("dsp irq missing");
   a_copy_eight: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RULE14
      $rose(state_reg == atr_pkg::CAP_COPY) |-> (state_reg == atr_pkg::CAP_COPY)[*8]
      ##1 state_reg == atr_pkg::CAP_IDLE)
      else $error("copy not eight words");
   a_thresh_flag: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RULE15
      thr_ev |=> irq_stat_reg[atr_pkg::IRQ_THR])
      else $error("threshold flag missing");
   a_ext_follow: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RULE10
      ##1 ext_clk_o == $past(tgt_reg[atr_pkg::TGT_EXTOUT]))
      else $error("ext clock not following");
   a_gain_out: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RULE16
      wr_gain |=> ##1 pga_gain_o == $past(avs_writedata[15:0], 2))
      else $error("gain not applied");
   a_reset_low: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RULE18
      $rose(resetn_i) |-> tgt_next == 5'h00)
      else $error("route not low after reset");
   a_busy_ignore: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RULE13
      state_reg != atr_pkg::CAP_IDLE |=> !adc_convst_o)
      else $error("trigger accepted while busy");
   a_conv_state: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RULE13
      adc_convst_o |-> state_reg == atr_pkg::CAP_CONV)
      else $error("start pulse outside conversion");
   sequence s_capture_done;
      state_reg == atr_pkg::CAP_CONV && done_ev;
   endsequence
   a_copy_start: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RULE14
      s_capture_done |=> state_reg == atr_pkg::CAP_COPY && ch_reg == 3'h0)
      else $error("copy not started");
   a_fifo_push: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RULE14
      push && !pop |=> level_reg == $past(level_reg) + 7'h01)
      else $error("level not raised by push");
   a_fifo_pop: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RULE14
      pop && !push |=> level_reg == $past(level_reg) - 7'h01)
      else $error("level not lowered by pop");
   a_thr_irq: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RULE15
      thr_ev && irq_en_reg[atr_pkg::IRQ_THR] |=> dsp_irq_o)
      else $error("threshold irq missing");
   a_irq_quiet: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RULE11
      (irq_stat_reg & irq_en_reg) == 4'h0 && ev == 4'h0 |=> !host_irq_o && !dsp_irq_o)
      else $error("irq without enabled status");
   a_host_hold: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RULE11
      irq_stat_reg[atr_pkg::IRQ_HOST] && irq_en_reg[atr_pkg::IRQ_HOST] && !wr_clr
      |=> host_irq_o)
      else $error("host irq dropped");
   a_bus_wait: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      !avs_waitrequest |=> avs_waitrequest)
      else $error("answer longer than one cycle");
endmodule
`default_nettype wire

// ### src/atr_pkg.sv
`default_nettype none
package atr_pkg;
   // routing sources
   localparam logic [3:0] SRC_LOW    = 4'h0;
   localparam logic [3:0] SRC_HIGH   = 4'h1;
   localparam logic [3:0] SRC_TMR0   = 4'h2;
   localparam logic [3:0] SRC_TMR1   = 4'h3;
   localparam logic [3:0] SRC_EXT0   = 4'h4;
   localparam logic [3:0] SRC_EXT1   = 4'h5;
   localparam logic [3:0] SRC_DSPSTB = 4'h6;
   localparam logic [3:0] SRC_HOSTSTB = 4'h7;
   localparam int         NUM_SRC    = 8;
   // routing targets
   localparam int TGT_ADCLK  = 0;
   localparam int TGT_ADGATE = 1;
   localparam int TGT_EXTOUT = 2;
   localparam int TGT_HOSTIRQ = 3;
   localparam int TGT_DSPIRQ = 4;
   localparam int NUM_TGT    = 5;
   // timer modes
   localparam logic [1:0] TM_POS = 2'h0;
   localparam logic [1:0] TM_NEG = 2'h1;
   localparam logic [1:0] TM_SQR = 2'h2;
   // timer base period in ps and its count at 10 MHz
   localparam int TMR_BASE_PS = 66700;
   localparam int CLK_PS      = 100000;
   localparam int TMR_BASE_CYC = (TMR_BASE_PS + CLK_PS - 1) / CLK_PS;
   // converter
   localparam int NCH    = 8;
   localparam int RES_W  = 16;
   localparam int FIFO_DEPTH = 64;
   localparam int FIFO_AW = 6;
   // register word addresses (avalon word index)
   localparam logic [4:0] A_ROUTE0   = 5'h00;
   localparam logic [4:0] A_TMRCFG0  = 5'h05;
   localparam logic [4:0] A_TMRCFG1  = 5'h06;
   localparam logic [4:0] A_DSPSTB   = 5'h07;
   localparam logic [4:0] A_HOSTSTB  = 5'h08;
   localparam logic [4:0] A_GAIN     = 5'h09;
   localparam logic [4:0] A_THRESH   = 5'h0a;
   localparam logic [4:0] A_FIFO     = 5'h0b;
   localparam logic [4:0] A_LEVEL    = 5'h0c;
   localparam logic [4:0] A_IRQSTAT  = 5'h0d;
   localparam logic [4:0] A_IRQEN    = 5'h0e;
   localparam logic [4:0] A_IRQCLR   = 5'h0f;
   // interrupt status bits
   localparam int IRQ_HOST  = 0;
   localparam int IRQ_DSP   = 1;
   localparam int IRQ_THR   = 2;
   localparam int IRQ_OVF   = 3;
   localparam int NIRQ      = 4;
   // reset values and unmapped read value
   localparam logic [1:0]  GAIN_RST   = 2'h0;
   localparam logic [6:0]  THRESH_RST = 7'h08;
   localparam logic [15:0] TMR_PER_RST = 16'h000a;
   localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
   // capture fsm
   typedef enum logic [2:0] {
      CAP_IDLE = 3'b001,
      CAP_CONV = 3'b010,
      CAP_COPY = 3'b100
   } atr_cap_t;
endpackage
`default_nettype wire

// ### src/atr_timer.sv
`default_nettype none
module atr_timer
(
   input  wire logic        mclk_i,
   input  wire logic        resetn_i,
   input  wire logic        en_i,
   input  wire logic [1:0]  mode_i,
   input  wire logic [15:0] period_i,
   output logic             out_o
);
   logic [15:0] cnt_reg;
   logic [15:0] base_reg;
   logic        sq_reg;
   logic        tick;
   logic        wrap;
   // base tick: one per TMR_BASE_CYC clocks, base period rounded up to one clock; period counts in base ticks
   assign tick = (base_reg == 16'(atr_pkg::TMR_BASE_CYC - 1));
   assign wrap = tick && (period_i == 16'h0000 || cnt_reg >= period_i - 16'h0001);
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i || !en_i)
      begin
         base_reg <= 16'h0000;
         cnt_reg  <= 16'h0000;
         sq_reg   <= 1'b0;
         out_o    <= 1'b0;
      end
      else
      begin
         base_reg <= tick ? 16'h0000 : base_reg + 16'h0001;
         if (tick)
            cnt_reg <= wrap ? 16'h0000 : cnt_reg + 16'h0001;
         if (wrap)
            sq_reg <= ~sq_reg;
         case (mode_i) // RULE2
            atr_pkg::TM_POS: out_o <= wrap;
            atr_pkg::TM_NEG: out_o <= ~wrap;
            default:         out_o <= sq_reg ^ wrap;
         endcase
      end
   end
endmodule
`default_nettype wire

// ### sim/atr_adc_model.sv
`default_nettype none
module atr_adc_model
(
   input  wire logic          mclk_i,
   input  wire logic          resetn_i,
   input  wire logic          convst_i,
   output logic               done_o,
   output logic [127:0]       data_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0]   step_reg;
   logic [3:0]   conv_reg;
   logic [127:0] pat;
   // ==========================================
   // sample pattern: every channel from one conversion
   for (genvar k = 0; k < 8; k++)
   begin : g_pat
      assign pat[k*16 +: 16] = {4'ha, conv_reg, 4'h0, 4'(k)};
   end
   // ==========================================
   // conversion timing, data inverted while not valid
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         step_reg <= 8'h00;
         conv_reg <= 4'h0;
         done_o   <= 1'b0;
         data_o   <= '1;
      end
      else if (step_reg == 8'h00)
      begin
         if (convst_i)
            step_reg <= 8'h01;
      end
      else
      begin
         step_reg <= step_reg + 8'h01;
         if (step_reg == 8'h14)
         begin
            done_o <= 1'b1;
            data_o <= pat;
         end
         if (step_reg == 8'h32)
         begin
            done_o   <= 1'b0;
            data_o   <= ~pat;
            step_reg <= 8'h00;
            conv_reg <= conv_reg + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ### sim/tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic         mclk_i;
   logic         resetn_i;
   logic [4:0]   avs_address;
   logic         avs_read;
   logic         avs_write;
   logic [31:0]  avs_writedata;
   logic [31:0]  avs_readdata;
   logic         avs_waitrequest;
   logic [1:0]   ext_trig_i;
   logic         ext_clk_o;
   logic         adc_convst_o;
   logic         adc_done_i;
   logic [127:0] adc_data_i;
   logic [15:0]  pga_gain_o;
   logic         host_irq_o;
   logic         dsp_irq_o;
   int           err_total;
   int           n_checks;
   logic [31:0]  rdat;
   int           hi;
   atr_top i_dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .ext_trig_i(ext_trig_i), .ext_clk_o(ext_clk_o), .adc_convst_o(adc_convst_o),
      .adc_done_i(adc_done_i), .adc_data_i(adc_data_i), .pga_gain_o(pga_gain_o),
      .host_irq_o(host_irq_o), .dsp_irq_o(dsp_irq_o));
   atr_adc_model i_adc (.mclk_i(mclk_i), .resetn_i(resetn_i), .convst_i(adc_convst_o),
      .done_o(adc_done_i), .data_o(adc_data_i));
   always #50 mclk_i = ~mclk_i;
   // ==========================================
   // common tasks
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk_i);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      do
      begin
         @(posedge mclk_i);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rdat = avs_readdata;
      if (n >= 50)
         chk(32'h1, 32'h0);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic route(input int t, input logic [3:0] s);
      bus(1'b1, 5'(atr_pkg::A_ROUTE0 + t), {28'h0, s});
      repeat (8) @(posedge mclk_i);
   endtask
   task automatic count(input int sel, input int n);
      hi = 0;
      repeat (n)
      begin
         @(posedge mclk_i);
         hi += (sel == 0) ? int'(ext_clk_o === 1'b1) : int'(adc_convst_o === 1'b1);
      end
   endtask
   // ==========================================
   // scenarios
   task automatic t_reset();
      for (int t = 0; t < atr_pkg::NUM_TGT; t++)
      begin
         bus(1'b0, 5'(atr_pkg::A_ROUTE0 + t), 32'h0);
         chk(rdat & 32'hf, {28'h0, atr_pkg::SRC_LOW});
      end
      chk({ext_clk_o, host_irq_o, dsp_irq_o}, 32'h0);
      bus(1'b0, atr_pkg::A_THRESH, 32'h0);
      chk(rdat & 32'h7f, 32'h08);
      bus(1'b0, 5'h1f, 32'h0);
      chk(rdat, atr_pkg::RD_UNMAPPED);
   endtask
   task automatic t_levels();
      route(atr_pkg::TGT_EXTOUT, atr_pkg::SRC_HIGH);
      chk(ext_clk_o, 32'h1);
      route(atr_pkg::TGT_EXTOUT, atr_pkg::SRC_LOW);
      chk(ext_clk_o, 32'h0);
      ext_trig_i <= 2'h1;
      route(atr_pkg::TGT_EXTOUT, atr_pkg::SRC_EXT0);
      chk(ext_clk_o, 32'h1);
      route(atr_pkg::TGT_EXTOUT, atr_pkg::SRC_EXT1);
      chk(ext_clk_o, 32'h0);
      ext_trig_i <= 2'h2;
      repeat (8) @(posedge mclk_i);
      chk(ext_clk_o, 32'h1);
   endtask
   task automatic t_strobe();
      route(atr_pkg::TGT_EXTOUT, atr_pkg::SRC_DSPSTB);
      bus(1'b1, atr_pkg::A_DSPSTB, 32'h0);
      count(0, 16);
      chk(hi, 32'h1);
      route(atr_pkg::TGT_EXTOUT, atr_pkg::SRC_HOSTSTB);
      bus(1'b1, atr_pkg::A_HOSTSTB, 32'h0);
      count(0, 16);
      chk(hi, 32'h1);
   endtask
   task automatic t_timer();
      for (int t = 0; t < 2; t++)
      begin
         route(atr_pkg::TGT_EXTOUT, 4'(atr_pkg::SRC_TMR0 + t));
         for (int m = 0; m < 3; m++)
         begin
            bus(1'b1, 5'(atr_pkg::A_TMRCFG0 + t), {13'h0, 1'b1, 2'(m), 16'h0004});
            repeat (10) @(posedge mclk_i);
            count(0, 64);
            if (m == 0)
               chk(32'(hi < 32 && hi > 0), 32'h1);
            else if (m == 1)
               chk(32'(hi > 32 && hi < 64), 32'h1);
            else
               chk(hi, 32'h20);
         end
         bus(1'b1, 5'(atr_pkg::A_TMRCFG0 + t), 32'h0);
      end
   endtask
   task automatic t_capture();
      route(atr_pkg::TGT_ADCLK, atr_pkg::SRC_DSPSTB);
      bus(1'b1, atr_pkg::A_DSPSTB, 32'h0);
      count(1, 30);
      chk(hi, 32'h0);
      route(atr_pkg::TGT_ADGATE, atr_pkg::SRC_HIGH);
      bus(1'b1, atr_pkg::A_IRQEN, 32'h4);
      bus(1'b1, atr_pkg::A_DSPSTB, 32'h0);
      count(1, 30);
      chk(hi, 32'h1);
      repeat (40) @(posedge mclk_i);
      bus(1'b0, atr_pkg::A_LEVEL, 32'h0);
      chk(rdat & 32'h7f, 32'h08);
      chk(dsp_irq_o, 32'h1);
      for (int k = 0; k < atr_pkg::NCH; k++)
      begin
         bus(1'b0, atr_pkg::A_FIFO, 32'h0);
         chk(rdat & 32'hffff, {16'h0, 8'ha0, 4'h0, 4'(k)});
      end
      bus(1'b1, atr_pkg::A_IRQCLR, 32'h4);
      repeat (3) @(posedge mclk_i);
      chk(dsp_irq_o, 32'h0);
   endtask
   task automatic t_irq();
      bus(1'b1, atr_pkg::A_IRQEN, 32'h3);
      route(atr_pkg::TGT_HOSTIRQ, atr_pkg::SRC_HOSTSTB);
      bus(1'b1, atr_pkg::A_HOSTSTB, 32'h0);
      repeat (6) @(posedge mclk_i);
      chk(host_irq_o, 32'h1);
      bus(1'b1, atr_pkg::A_IRQCLR, 32'h1);
      bus(1'b1, atr_pkg::A_IRQEN, 32'h2);
      bus(1'b1, atr_pkg::A_HOSTSTB, 32'h0);
      repeat (6) @(posedge mclk_i);
      chk(host_irq_o, 32'h0);
      bus(1'b0, atr_pkg::A_IRQSTAT, 32'h0);
      chk(rdat & 32'h1, 32'h1);
      route(atr_pkg::TGT_DSPIRQ, atr_pkg::SRC_HIGH);
      chk(dsp_irq_o, 32'h1);
      bus(1'b1, atr_pkg::A_IRQCLR, 32'h3);
      repeat (3) @(posedge mclk_i);
      chk(dsp_irq_o, 32'h0);
   endtask
   task automatic t_gain();
      bus(1'b1, atr_pkg::A_GAIN, 32'h1be4);
      repeat (2) @(posedge mclk_i);
      chk(pga_gain_o, 32'h1be4);
      bus(1'b0, atr_pkg::A_GAIN, 32'h0);
      chk(rdat & 32'hffff, 32'h1be4);
   endtask
   // ==========================================
   // main sequence and watchdog
   initial
   begin
      mclk_i = 1'b0;
      resetn_i = 1'b0;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      ext_trig_i = 2'h0;
      err_total = 0;
      n_checks = 0;
      repeat (2) @(posedge mclk_i);
      resetn_i <= 1'b1;
      t_reset();
      t_levels();
      t_strobe();
      t_timer();
      t_capture();
      t_irq();
      t_gain();
      conclude();
   end
   initial
   begin
      #2000000;
      err_total++;
      conclude();
   end
endmodule
`default_nettype wire
